// ---- arith_unit_regs.svh ----
/*
  constants for the arithmetic execution unit: operation codes,
  flag bit positions and reset values.
  assumes inclusion by bare name from the package and the design file.
*/
`ifndef ARITH_UNIT_REGS_SVH
`define ARITH_UNIT_REGS_SVH

`define OPC_SUM          5'h00
`define OPC_DIFF         5'h01
`define OPC_SUM_CARRY    5'h02
`define OPC_DIFF_BORROW  5'h03
`define OPC_STEP_UP      5'h04
`define OPC_STEP_DOWN    5'h05
`define OPC_WORD_PLUS    5'h06
`define OPC_WORD_MINUS   5'h07
`define OPC_FIX_SUM      5'h08
`define OPC_FIX_DIFF     5'h09
`define OPC_PRODUCT      5'h0A
`define OPC_QUOTIENT     5'h0B
`define OPC_COMPARE      5'h0C
`define OPC_NEGATE       5'h0D

`define FLAG_C_BIT       0
`define FLAG_V_BIT       1
`define FLAG_Z_BIT       2
`define FLAG_N_BIT       3
`define FLAG_H_BIT       4
`define FLAGS_RESET      5'h00
`define RESULT_RESET     16'h0000

`endif

// ---- arith_unit_pkg.sv ----
/*
  types for the arithmetic execution unit.
  assumes arith_unit_regs.svh is on the include path.
*/
`include "arith_unit_regs.svh"

package arith_unit_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_DIV  = 2'h2
  } state_type;

endpackage

// ---- cpu_arithmetic_unit.sv ----
/*
  arithmetic datapath: add, subtract, carry forms, step, small word
  steps, decimal adjust, multiply, divide, compare and negate, with
  the condition flags register.
  assumes the decoder presents one operation per start pulse, with
  register operands already read, and accepts the result on done.
*/
`timescale 1ns/1ns
`include "arith_unit_regs.svh"

// Functional notes
// - sum and difference combine two registers, and sum also takes an immediate, result to destination.
// - plain difference refuses an immediate operand.
// - word sum and difference need two register operands; immediate sum is byte only.
// - carry forms work on bytes and add or subtract the carry flag with a register operand.
// - carry forms also take an immediate byte as second operand.
// - step up and step down add or subtract one on a byte register.
// - small word plus and minus use an immediate of one or two on a 16-bit register.
// - decimal fix converts a byte sum or difference to packed BCD using the flags.
// - unsigned product multiplies two bytes into a 16-bit result.
// - unsigned quotient divides 16 bits by 8 giving 8-bit quotient and remainder.
// - comparison subtracts for flags only and writes no register.
// - word comparison needs two registers; immediate comparison is byte only.
// - negate replaces a byte with zero minus its value.
// - the flags register holds half carry, negative, zero, overflow and carry, used by carry and fix forms.
module cpu_arithmetic_unit #(
  parameter int DIV_STEPS = 8
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic        start_in,
  input  wire logic [4:0]  op_in,
  input  wire logic        word_in,
  input  wire logic        imm_in,
  input  wire logic [15:0] dst_in,
  input  wire logic [15:0] src_in,
  input  wire logic [7:0]  imm_val_in,
  output logic [15:0]      result_out,
  output logic             write_out,
  output logic             done_out,
  output logic             illegal_out,
  output logic [3:0]       flags_out
);

  arith_unit_pkg::state_type state_q, state_d;
  logic [15:0] result_q, result_d;
  logic        write_q, write_d;
  logic        done_q, done_d;
  logic        illegal_q, illegal_d;
  logic [4:0]  flags_q, flags_d;
  logic [15:0] rem_q, rem_d;
  logic [7:0]  quo_q, quo_d;
  logic [7:0]  divisor_q, divisor_d;
  logic [3:0]  count_q, count_d;

  // n and z from a result of the given width
  function automatic logic [1:0] nz_of(input logic [15:0] r, input logic wide);
    nz_of = wide ? {r[15], r == 16'h0000} : {r[7], r[7:0] == 8'h00};
  endfunction

  // adder shared by the sum, difference, carry, step, compare and negate forms
  function automatic logic [20:0] add_flags(input logic [15:0] a, input logic [15:0] b,
                                            input logic sub, input logic cin, input logic wide);
    logic [16:0] s;
    logic [15:0] bb;
    logic        c;
    logic        v;
    logic        h;
    logic [1:0]  nz;
    s  = 17'h00000;
    bb = sub ? ~b : b;
    c  = 1'b0;
    v  = 1'b0;
    h  = 1'b0;
    if (wide) begin
      s = {1'b0, a} + {1'b0, bb} + {16'h0000, sub ^ cin};
      c = s[16] ^ sub;
      v = (a[15] == bb[15]) && (s[15] != a[15]);
      h = (a[11:0] + bb[11:0] + {11'h000, sub ^ cin}) > 13'h0FFF;
    end else begin
      s = {8'h00, {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, sub ^ cin}};
      c = s[8] ^ sub;
      v = (a[7] == bb[7]) && (s[7] != a[7]);
      h = ({1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub ^ cin}) > 5'h0F;
      s[16:8] = {1'b0, a[15:8]};
    end
    nz = nz_of(s[15:0], wide);
    add_flags = {s[15:0], h ^ sub, nz, v, c};
  endfunction

  // next-state logic for the whole datapath
  always_comb begin
    logic [15:0] opnd;
    logic [20:0] r;
    logic [7:0]  fix;
    logic        fc;
    logic [16:0] trial;
    opnd      = imm_in ? {8'h00, imm_val_in} : src_in;
    r         = 21'h000000;
    fix       = 8'h00;
    fc        = 1'b0;
    trial     = {1'b0, rem_q} - {1'b0, divisor_q, 8'h00};
    state_d   = state_q;
    result_d  = result_q;
    write_d   = 1'b0;
    done_d    = 1'b0;
    illegal_d = 1'b0;
    flags_d   = flags_q;
    rem_d     = rem_q;
    quo_d     = quo_q;
    divisor_d = divisor_q;
    count_d   = count_q;
    unique case (state_q)
      arith_unit_pkg::ST_IDLE: begin
        if (start_in) begin
          done_d = 1'b1;
          unique case (op_in)
            `OPC_SUM, `OPC_DIFF, `OPC_COMPARE: begin
              if ((word_in && imm_in) || (op_in == `OPC_DIFF && imm_in)) begin
                illegal_d = 1'b1;
              end else begin
                r        = add_flags(dst_in, opnd, op_in != `OPC_SUM, 1'b0, word_in);
                flags_d  = r[4:0];
                result_d = r[20:5];
                write_d  = op_in != `OPC_COMPARE;
              end
            end
            `OPC_SUM_CARRY, `OPC_DIFF_BORROW: begin
              r        = add_flags(dst_in, opnd, op_in == `OPC_DIFF_BORROW,
                                   flags_q[`FLAG_C_BIT], 1'b0);
              flags_d  = r[4:0];
              result_d = r[20:5];
              write_d  = 1'b1;
            end
            `OPC_STEP_UP, `OPC_STEP_DOWN: begin
              r        = add_flags(dst_in, 16'h0001, op_in == `OPC_STEP_DOWN, 1'b0, 1'b0);
              flags_d  = {flags_q[`FLAG_H_BIT], r[3:1], flags_q[`FLAG_C_BIT]};
              result_d = r[20:5];
              write_d  = 1'b1;
            end
            `OPC_WORD_PLUS, `OPC_WORD_MINUS: begin
              if (imm_val_in != 8'h01 && imm_val_in != 8'h02) begin
                illegal_d = 1'b1;
              end else begin
                result_d = (op_in == `OPC_WORD_PLUS) ? dst_in + {8'h00, imm_val_in}
                                                     : dst_in - {8'h00, imm_val_in};
                write_d  = 1'b1;
              end
            end
            `OPC_FIX_SUM: begin
              fc  = flags_q[`FLAG_C_BIT] || dst_in[7:0] > 8'h99;
              fix = {fc ? 4'h6 : 4'h0,
                     (flags_q[`FLAG_H_BIT] || dst_in[3:0] > 4'h9) ? 4'h6 : 4'h0};
              result_d = {dst_in[15:8], dst_in[7:0] + fix};
              flags_d  = {flags_q[`FLAG_H_BIT], nz_of(result_d, 1'b0), flags_q[`FLAG_V_BIT], fc};
              write_d  = 1'b1;
            end
            `OPC_FIX_DIFF: begin
              fc  = flags_q[`FLAG_C_BIT];
              fix = {fc ? 4'h6 : 4'h0, flags_q[`FLAG_H_BIT] ? 4'h6 : 4'h0};
              result_d = {dst_in[15:8], dst_in[7:0] - fix};
              flags_d  = {flags_q[`FLAG_H_BIT], nz_of(result_d, 1'b0), flags_q[`FLAG_V_BIT], fc};
              write_d  = 1'b1;
            end
            `OPC_PRODUCT: begin
              result_d = {8'h00, dst_in[7:0]} * {8'h00, src_in[7:0]};
              write_d  = 1'b1;
            end
            `OPC_QUOTIENT: begin
              if (src_in[7:0] == 8'h00) begin
                illegal_d = 1'b1;                          // divide by zero refused
              end else begin
                done_d    = 1'b0;
                rem_d     = dst_in;
                divisor_d = src_in[7:0];
                quo_d     = 8'h00;
                count_d   = 4'h0;
                state_d   = arith_unit_pkg::ST_DIV;
              end
            end
            `OPC_NEGATE: begin
              r        = add_flags(16'h0000, dst_in, 1'b1, 1'b0, 1'b0);
              flags_d  = r[4:0];
              result_d = {dst_in[15:8], r[12:5]};
              write_d  = 1'b1;
            end
            default: illegal_d = 1'b1;
          endcase
        end
      end
      arith_unit_pkg::ST_DIV: begin
        // restoring division, one quotient bit per cycle
        trial = {1'b0, rem_q[14:0], 1'b0} - {1'b0, divisor_q, 8'h00};
        if (rem_q[15] || !trial[16]) begin
          rem_d = trial[15:0];
          quo_d = {quo_q[6:0], 1'b1};
        end else begin
          rem_d = {rem_q[14:0], 1'b0};
          quo_d = {quo_q[6:0], 1'b0};
        end
        count_d = count_q + 4'h1;
        if (count_q == 4'(DIV_STEPS - 1)) begin
          result_d = {rem_d[15:8], quo_d};
          write_d  = 1'b1;
          done_d   = 1'b1;
          state_d  = arith_unit_pkg::ST_IDLE;
        end
      end
      default: state_d = arith_unit_pkg::ST_IDLE;
    endcase
  end

  // state registers, frozen while the clock enable is low
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q   <= arith_unit_pkg::ST_IDLE;
      result_q  <= `RESULT_RESET;
      write_q   <= 1'b0;
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
      flags_q   <= `FLAGS_RESET;
      rem_q     <= 16'h0000;
      quo_q     <= 8'h00;
      divisor_q <= 8'h00;
      count_q   <= 4'h0;
    end else if (ce_in) begin
      state_q   <= state_d;
      result_q  <= result_d;
      write_q   <= write_d;
      done_q    <= done_d;
      illegal_q <= illegal_d;
      flags_q   <= flags_d;
      rem_q     <= rem_d;
      quo_q     <= quo_d;
      divisor_q <= divisor_d;
      count_q   <= count_d;
    end
  end

  // outputs straight from flip-flops
  always_comb begin
    result_out  = result_q;
    write_out   = write_q;
    done_out    = done_q;
    illegal_out = illegal_q;
    flags_out   = flags_q[3:0];
  end

endmodule

// ---- arith_unit_checker.sv ----
/*
  checker for the arithmetic unit: timing, refusal and flag relations.
  assumes it is bound to cpu_arithmetic_unit with default opcodes.
*/
`timescale 1ns/1ns
`include "arith_unit_regs.svh"
module arith_unit_checker #(
  parameter int DIV_STEPS = 8
) (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  input wire logic        start_in,
  input wire logic [4:0]  op_in,
  input wire logic        word_in,
  input wire logic        imm_in,
  input wire logic [15:0] dst_in,
  input wire logic [15:0] src_in,
  input wire logic [7:0]  imm_val_in,
  input wire logic [15:0] result_out,
  input wire logic        write_out,
  input wire logic        done_out,
  input wire logic        illegal_out,
  input wire logic [3:0]  flags_out
);
  logic busy_q;
  logic tk;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // request taken while idle; the unit is idle again once done shows
  assign tk = start_in && ce_in && (!busy_q || done_out);
  // divide in progress; a refused divide never makes the unit busy
  always_ff @(posedge clk_in) begin
    if (rst_in) busy_q <= 1'b0;
    else if (tk && op_in == `OPC_QUOTIENT && src_in[7:0] != 8'h00) busy_q <= 1'b1;
    else if (ce_in && done_out) busy_q <= 1'b0;
  end
  a_single_done: assert property (tk && op_in != `OPC_QUOTIENT |=> done_out)
    else $error("single cycle op did not finish");
  a_compare_no_write: assert property (tk && op_in == `OPC_COMPARE |=> done_out && !write_out)
    else $error("compare wrote a result");
  a_illegal_no_write: assert property (illegal_out |-> done_out && !write_out && $stable(flags_out))
    else $error("refused op changed state");
  a_diff_imm_refused: assert property (tk && imm_in && op_in == `OPC_DIFF |=> illegal_out)
    else $error("difference with immediate taken");
  a_word_imm_refused: assert property (tk && imm_in && word_in && op_in == `OPC_SUM |=> illegal_out)
    else $error("word sum with immediate taken");
  a_div_latency: assert property (tk && op_in == `OPC_QUOTIENT && src_in[7:0] != 8'h00
    |=> !done_out [*8] ##1 done_out && write_out)
    else $error("divide latency wrong");
  a_product_value: assert property (tk && op_in == `OPC_PRODUCT
    |=> result_out == $past(dst_in[7:0]) * $past(src_in[7:0]) && $stable(flags_out))
    else $error("product wrong");
  a_step_keeps_carry: assert property (tk && op_in == `OPC_STEP_UP |=> flags_out[0] == $past(flags_out[0]))
    else $error("step changed carry");
  c_divide: cover property (done_out && busy_q);
  c_illegal: cover property (illegal_out);
  c_compare: cover property (tk && op_in == `OPC_COMPARE);
endmodule

// ---- reg_file_model.sv ----
/*
  register file stand-in: keeps the last value written back.
  assumes write_in is the unit's one-cycle write pulse.
*/
`timescale 1ns/1ns
module reg_file_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        write_in,
  input  wire logic [15:0] result_in,
  output logic [15:0]      value_out
);
  // capture written result
  always_ff @(posedge clk_in) begin
    if (rst_in) value_out <= 16'h0000;
    else if (write_in) value_out <= result_in;
  end
endmodule

// ---- testbench.sv ----
/*
  testbench for the arithmetic unit, one task per scenario.
  assumes the default opcodes and DIV_STEPS of 8.
*/
`timescale 1ns/1ns
`include "arith_unit_regs.svh"
module testbench;
  logic clk_in, rst_in, ce_in, start_in, word_in, imm_in;
  logic [4:0] op_in;
  logic [15:0] dst_in, src_in, result_out, rf;
  logic [7:0] imm_val_in;
  logic write_out, done_out, illegal_out, r_wr, r_ill;
  logic [3:0] flags_out, r_fl;
  logic [15:0] r_res;
  int miscompares, n_checks, cyc, r_lat;
  cpu_arithmetic_unit #(.DIV_STEPS(8)) i_cpu_arithmetic_unit (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .start_in(start_in), .op_in(op_in), .word_in(word_in), .imm_in(imm_in), .dst_in(dst_in), .src_in(src_in),
    .imm_val_in(imm_val_in), .result_out(result_out), .write_out(write_out), .done_out(done_out),
    .illegal_out(illegal_out), .flags_out(flags_out));
  reg_file_model i_reg_file_model (.clk_in(clk_in), .rst_in(rst_in), .write_in(write_out),
    .result_in(result_out), .value_out(rf));
  // clock and cycle ceiling
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one request, wait for done under a bound
  task automatic run(input logic [4:0] op, input logic w, input logic i, input logic [15:0] d,
                     input logic [15:0] s, input logic [7:0] v);
    // an idle edge first, so the strobe never falls and rises in one step
    @(posedge clk_in) #1;
    op_in      = op;
    word_in    = w;
    imm_in     = i;
    dst_in     = d;
    src_in     = s;
    imm_val_in = v;
    start_in   = 1'b1;
    @(posedge clk_in) #1;
    start_in = 1'b0;
    for (r_lat = 1; r_lat < 20 && done_out !== 1'b1; r_lat++) @(posedge clk_in) #1;
    r_res = result_out;
    r_wr  = write_out;
    r_ill = illegal_out;
    r_fl  = flags_out;
  endtask
  task automatic t_sum;
    run(`OPC_SUM, 0, 0, 16'h127F, 16'h0001, 8'h00);
    chk(r_res, 16'h1280);
    chk(r_fl, 4'hA);
    @(posedge clk_in) #1;
    chk(rf, 16'h1280);
    run(`OPC_SUM, 1, 0, 16'h8000, 16'h8000, 8'h00);
    chk(r_res, 16'h0000);
    chk(r_fl, 4'h7);
    run(`OPC_SUM, 0, 1, 16'h0005, 16'h0000, 8'h03);
    chk(r_res, 16'h0008);
    run(`OPC_SUM, 1, 1, 16'h0005, 16'h0000, 8'h03);
    chk(r_ill, 1'b1);
    chk(r_fl, 4'h0);
    run(`OPC_DIFF, 0, 0, 16'h0010, 16'h0020, 8'h00);
    chk(r_res, 16'h00F0);
    chk(r_fl, 4'h9);
    run(`OPC_DIFF, 0, 1, 16'h0010, 16'h0000, 8'h01);
    chk(r_ill, 1'b1);
    chk(r_wr, 1'b0);
    $display("sum and difference done");
  endtask
  task automatic t_carry;
    run(`OPC_SUM_CARRY, 0, 0, 16'h0010, 16'h0001, 8'h00);
    chk(r_res, 16'h0012);
    chk(r_fl, 4'h0);
    run(`OPC_DIFF, 0, 0, 16'h0000, 16'h0001, 8'h00);
    chk(r_fl, 4'h9);
    run(`OPC_DIFF_BORROW, 0, 1, 16'h0005, 16'h0000, 8'h02);
    chk(r_res, 16'h0002);
    run(`OPC_DIFF, 0, 0, 16'h0000, 16'h0001, 8'h00);
    run(`OPC_STEP_UP, 0, 0, 16'h00FF, 16'h0000, 8'h00);
    chk(r_res, 16'h0000);
    chk(r_fl, 4'h5);
    run(`OPC_STEP_DOWN, 0, 0, 16'h0080, 16'h0000, 8'h00);
    chk(r_res, 16'h007F);
    chk(r_fl, 4'h3);
    $display("carry and step done");
  endtask
  task automatic t_word;
    run(`OPC_WORD_PLUS, 0, 1, 16'hFFFF, 16'h0000, 8'h02);
    chk(r_res, 16'h0001);
    chk(r_fl, 4'h3);
    run(`OPC_WORD_MINUS, 0, 1, 16'h0000, 16'h0000, 8'h01);
    chk(r_res, 16'hFFFF);
    run(`OPC_WORD_MINUS, 0, 1, 16'h0000, 16'h0000, 8'h03);
    chk(r_ill, 1'b1);
    run(`OPC_SUM, 0, 0, 16'h0015, 16'h0027, 8'h00);
    run(`OPC_FIX_SUM, 0, 0, 16'h003C, 16'h0000, 8'h00);
    chk(r_res, 16'h0042);
    run(`OPC_DIFF, 0, 0, 16'h0042, 16'h0015, 8'h00);
    run(`OPC_FIX_DIFF, 0, 0, 16'h002D, 16'h0000, 8'h00);
    chk(r_res, 16'h0027);
    $display("word step and decimal done");
  endtask
  task automatic t_muldiv;
    run(`OPC_PRODUCT, 0, 0, 16'h00FF, 16'h00FF, 8'h00);
    chk(r_res, 16'hFE01);
    run(`OPC_QUOTIENT, 0, 0, 16'h1234, 16'h0056, 8'h00);
    chk(r_res, 16'h1036);
    chk(r_lat, 9);
    run(`OPC_QUOTIENT, 0, 0, 16'h1234, 16'h0000, 8'h00);
    chk(r_ill, 1'b1);
    run(`OPC_COMPARE, 0, 0, 16'h0005, 16'h0005, 8'h00);
    chk(r_wr, 1'b0);
    chk(r_fl, 4'h4);
    run(`OPC_COMPARE, 1, 1, 16'h0005, 16'h0000, 8'h05);
    chk(r_ill, 1'b1);
    run(`OPC_NEGATE, 0, 0, 16'h0001, 16'h0000, 8'h00);
    chk(r_res, 16'h00FF);
    chk(r_fl, 4'h9);
    run(`OPC_NEGATE, 0, 0, 16'h0080, 16'h0000, 8'h00);
    chk(r_res, 16'h0080);
    chk(r_fl, 4'hB);
    $display("multiply divide compare negate done");
  endtask
  // clock enable low freezes the unit; a reset while idle between requests clears it
  task automatic t_hold;
    @(posedge clk_in) #1;
    ce_in    = 1'b0;
    op_in    = `OPC_SUM;
    word_in  = 1'b0;
    imm_in   = 1'b0;
    dst_in   = 16'h00FF;
    src_in   = 16'h0001;
    start_in = 1'b1;
    @(posedge clk_in) #1;
    start_in = 1'b0;
    chk(done_out, 1'b0);
    chk(result_out, 16'h0080);
    chk(flags_out, 4'hB);
    ce_in = 1'b1;
    @(posedge clk_in) #1;
    chk(done_out, 1'b0);
    rst_in = 1'b1;
    @(posedge clk_in) #1;
    rst_in = 1'b0;
    chk(result_out, `RESULT_RESET);
    chk(flags_out, `FLAGS_RESET);
    chk(rf, 16'h0000);
    run(`OPC_SUM, 0, 0, 16'h0001, 16'h0002, 8'h00);
    chk(r_res, 16'h0003);
    chk(r_fl, 4'h0);
    $display("hold and reset done");
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // reset, then the scenarios
  initial begin
    rst_in = 1'b1; ce_in = 1'b1; start_in = 1'b0; op_in = 5'h00; word_in = 1'b0; imm_in = 1'b0;
    dst_in = 16'h0000; src_in = 16'h0000; imm_val_in = 8'h00;
    repeat (12) @(posedge clk_in);
    #1 rst_in = 1'b0;
    t_sum();
    t_carry();
    t_word();
    t_muldiv();
    t_hold();
    test_done();
  end
endmodule
bind cpu_arithmetic_unit arith_unit_checker #(.DIV_STEPS(DIV_STEPS)) i_arith_unit_checker (.clk_in(clk_in),
  .rst_in(rst_in), .ce_in(ce_in), .start_in(start_in), .op_in(op_in), .word_in(word_in), .imm_in(imm_in),
  .dst_in(dst_in), .src_in(src_in), .imm_val_in(imm_val_in), .result_out(result_out), .write_out(write_out),
  .done_out(done_out), .illegal_out(illegal_out), .flags_out(flags_out));
